// ==== rtl/afm_pkg.sv ====
package afm_pkg;

  // ********************************************************
  // register map
  // ********************************************************
  localparam int          ADDR_W          = 6;
  localparam logic [5:0]  OFF_ARP_CFG     = 6'h00;
  localparam logic [5:0]  OFF_ICMP_CFG    = 6'h04;
  localparam logic [5:0]  OFF_SRC_MODE    = 6'h08;
  localparam logic [5:0]  OFF_SRC_RANGE   = 6'h0C;
  localparam logic [5:0]  OFF_DST_MODE    = 6'h10;
  localparam logic [5:0]  OFF_DST_RANGE   = 6'h14;
  localparam logic [5:0]  OFF_TCP_FLAGS   = 6'h18;
  localparam logic [5:0]  OFF_CTRL        = 6'h1C;
  localparam logic [5:0]  OFF_STATUS      = 6'h20;

  // ********************************************************
  // field positions
  // ********************************************************
  localparam int ARP_PRO_LSB   = 0;
  localparam int ARP_HRD_LSB   = 2;
  localparam int ICMP_TYPE_EN  = 0;
  localparam int ICMP_CODE_EN  = 1;
  localparam int ICMP_TYPE_LSB = 8;
  localparam int ICMP_CODE_LSB = 16;
  localparam int MODE_LSB      = 0;
  localparam int PORT_LO_LSB   = 0;
  localparam int PORT_HI_LSB   = 16;
  localparam int FLAG_W        = 2;
  localparam int CTRL_EN_BIT   = 0;
  localparam int STAT_HIT_BIT  = 0;
  localparam int STAT_SEEN_BIT = 1;
  localparam int STAT_CNT_LSB  = 16;
  localparam int FLAG_FIN      = 0;
  localparam int FLAG_SYN      = 1;
  localparam int FLAG_PSH      = 2;
  localparam int FLAG_ACK      = 3;
  localparam int FLAG_URG      = 4;
  localparam int NUM_FLAGS     = 5;

  // ********************************************************
  // reset values and constants
  // ********************************************************
  localparam logic [31:0] RST_ARP_CFG   = 32'h0000_000A;
  localparam logic [31:0] RST_ICMP_CFG  = 32'h0000_0000;
  localparam logic [31:0] RST_MODE      = 32'h0000_0000;
  localparam logic [31:0] RST_RANGE     = 32'hFFFF_0000;
  localparam logic [31:0] RST_TCP_FLAGS = 32'h0000_02AA;
  localparam logic [31:0] RST_CTRL      = 32'h0000_0001;
  localparam logic [15:0] PRO_IP        = 16'h0800;
  localparam logic [15:0] HRD_ETHERNET  = 16'h0001;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_DECERR   = 2'h3;

  // ********************************************************
  // types
  // ********************************************************
  typedef enum logic [1:0] {
    TRI_ZERO = 2'h0,
    TRI_ONE  = 2'h1,
    TRI_ANY  = 2'h2
  } afm_tri_e;

  typedef enum logic [1:0] {
    PM_ANY   = 2'h0,
    PM_EXACT = 2'h1,
    PM_RANGE = 2'h2
  } afm_pmode_e;

  typedef struct packed {
    logic        isArp;
    logic        isIcmp;
    logic        isTcp;
    logic        isUdp;
    logic [15:0] proType;
    logic [15:0] hrdType;
    logic [7:0]  icmpType;
    logic [7:0]  icmpCode;
    logic [15:0] srcPort;
    logic [15:0] dstPort;
    logic [4:0]  tcpFlags;
  } afm_hdr_s;

  typedef struct packed {
    logic [15:0] hi;
    logic [15:0] lo;
  } afm_range_s;

endpackage

// ==== rtl/afm_port_cond.sv ====
`timescale 1ns/1ps
`default_nettype none

// ********************************************************
// one port condition: don't-care, exact or inclusive range
// ********************************************************
module afm_port_cond #(
  parameter int PORT_W = 16
) (
  input  wire logic [1:0]        mode,
  input  wire logic [PORT_W-1:0] lo,
  input  wire logic [PORT_W-1:0] hi,
  input  wire logic [PORT_W-1:0] port,
  output logic                   care,
  output logic                   ok
);

  always_comb begin
    care = 1'b0;
    ok   = 1'b1;
    case (mode)
      afm_pkg::PM_EXACT: begin
        care = 1'b1;
        ok   = (port == lo);
      end
      // an inverted range (lo above hi) matches nothing
      afm_pkg::PM_RANGE: begin
        care = 1'b1;
        ok   = (port >= lo) && (port <= hi);
      end
      default: begin
        care = 1'b0;
        ok   = 1'b1;
      end
    endcase
  end

endmodule

`default_nettype wire

// ==== rtl/afm_field_matcher.sv ====
`timescale 1ns/1ps
`default_nettype none

// Operation
// [RULE1] arp protocol space: 0 rejects type 0x800, 1 requires it, any ignores
// [RULE2] icmp type is don't-care or an exact 8-bit value
// [RULE3] icmp code is don't-care or an exact 8-bit value
// [RULE4] source port is don't-care, exact 16-bit, or range
// [RULE5] source port range accepts only ports between both bounds inclusive
// [RULE6] destination port is don't-care, exact 16-bit, or range
// [RULE7] destination port range accepts only ports between both bounds inclusive
// [RULE8] fin setting 0 excludes fin set, 1 requires it, any ignores
// [RULE9] syn setting 0 excludes syn set, 1 requires it, any ignores
// [RULE10] psh setting 0 excludes psh set, 1 requires it, any ignores
// [RULE11] ack setting 0 excludes ack set, 1 requires it, any ignores
// [RULE12] urg setting 0 excludes urg set, 1 requires it, any ignores
// [RULE13] arp hardware space: 0 rejects ethernet, 1 requires it, any ignores
// [RULE14] hit only when all conditions hold; absent protocol never satisfies a condition
// [RULE15] parser presents decoded fields with a valid strobe before result is used
module afm_field_matcher #(
  parameter int CNT_W = 16
) (
  input  wire logic                    clock,
  input  wire logic                    rst_n,
  input  wire logic                    awvalid,
  output logic                         awready,
  input  wire logic [afm_pkg::ADDR_W-1:0] awaddr,
  input  wire logic                    wvalid,
  output logic                         wready,
  input  wire logic [31:0]             wdata,
  input  wire logic [3:0]              wstrb,
  output logic                         bvalid,
  input  wire logic                    bready,
  output logic [1:0]                   bresp,
  input  wire logic                    arvalid,
  output logic                         arready,
  input  wire logic [afm_pkg::ADDR_W-1:0] araddr,
  output logic                         rvalid,
  input  wire logic                    rready,
  output logic [31:0]                  rdata,
  output logic [1:0]                   rresp,
  input  wire logic                    hdrValid,
  input  wire afm_pkg::afm_hdr_s       hdr,
  output logic                         matchValid,
  output logic                         matchHit
);

  // ********************************************************
  // helpers
  // ********************************************************
  function automatic logic triOk(input logic [1:0] sel, input logic cond);
    case (sel)
      afm_pkg::TRI_ZERO: triOk = !cond;
      afm_pkg::TRI_ONE:  triOk = cond;
      default:           triOk = 1'b1;
    endcase
  endfunction

  function automatic logic triCare(input logic [1:0] sel);
    triCare = (sel == afm_pkg::TRI_ZERO) || (sel == afm_pkg::TRI_ONE);
  endfunction

  function automatic logic [31:0] strbMerge(input logic [31:0] old, input logic [31:0] data,
                                            input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = data[8*i +: 8];
      end
    end
    strbMerge = res;
  endfunction

  // ********************************************************
  // register bus slave
  // ********************************************************
  logic [31:0]               arpCfgQ, arpCfgD, icmpCfgQ, icmpCfgD;
  logic [31:0]               srcModeQ, srcModeD, srcRangeQ, srcRangeD;
  logic [31:0]               dstModeQ, dstModeD, dstRangeQ, dstRangeD;
  logic [31:0]               flagCfgQ, flagCfgD, ctrlQ, ctrlD;
  logic                      awHeldQ, awHeldD, wHeldQ, wHeldD;
  logic [afm_pkg::ADDR_W-1:0] awAddrQ, awAddrD;
  logic [31:0]               wDataQ, wDataD;
  logic [3:0]                wStrbQ, wStrbD;
  logic                      bvalidQ, bvalidD, rvalidQ, rvalidD;
  logic [1:0]                brespQ, brespD, rrespQ, rrespD;
  logic [31:0]               rdataQ, rdataD;
  logic                      hitQ, hitD, seenQ, seenD, mValidQ, mValidD;
  logic [CNT_W-1:0]          cntQ, cntD;
  logic                      awFire, wFire, doWrite;
  logic [afm_pkg::ADDR_W-1:0] wrAddr;
  logic [31:0]               wrData, statusWord;
  logic [3:0]                wrStrb;

  assign awready = !awHeldQ && !bvalidQ;
  assign wready  = !wHeldQ && !bvalidQ;
  assign arready = !rvalidQ;
  assign awFire  = awvalid && awready;
  assign wFire   = wvalid && wready;
  assign wrAddr  = awHeldQ ? awAddrQ : awaddr;
  assign wrData  = wHeldQ ? wDataQ : wdata;
  assign wrStrb  = wHeldQ ? wStrbQ : wstrb;
  // address and data may arrive in either order; write once both are here
  assign doWrite = (awHeldQ || awFire) && (wHeldQ || wFire) && !bvalidQ;

  always_comb begin
    statusWord = '0;
    statusWord[afm_pkg::STAT_HIT_BIT]              = hitQ;
    statusWord[afm_pkg::STAT_SEEN_BIT]             = seenQ;
    statusWord[afm_pkg::STAT_CNT_LSB +: CNT_W]     = cntQ;
  end

  always_comb begin
    arpCfgD   = arpCfgQ;
    icmpCfgD  = icmpCfgQ;
    srcModeD  = srcModeQ;
    srcRangeD = srcRangeQ;
    dstModeD  = dstModeQ;
    dstRangeD = dstRangeQ;
    flagCfgD  = flagCfgQ;
    ctrlD     = ctrlQ;
    awHeldD   = awHeldQ;
    awAddrD   = awAddrQ;
    wHeldD    = wHeldQ;
    wDataD    = wDataQ;
    wStrbD    = wStrbQ;
    bvalidD   = bvalidQ && !bready;
    brespD    = brespQ;
    if (awFire) begin
      awHeldD = 1'b1;
      awAddrD = awaddr;
    end
    if (wFire) begin
      wHeldD = 1'b1;
      wDataD = wdata;
      wStrbD = wstrb;
    end
    if (doWrite) begin
      awHeldD = 1'b0;
      wHeldD  = 1'b0;
      bvalidD = 1'b1;
      brespD  = afm_pkg::RESP_OKAY;
      case ({wrAddr[afm_pkg::ADDR_W-1:2], 2'b00})
        afm_pkg::OFF_ARP_CFG:   arpCfgD   = strbMerge(arpCfgQ, wrData, wrStrb);
        afm_pkg::OFF_ICMP_CFG:  icmpCfgD  = strbMerge(icmpCfgQ, wrData, wrStrb);
        afm_pkg::OFF_SRC_MODE:  srcModeD  = strbMerge(srcModeQ, wrData, wrStrb);
        afm_pkg::OFF_SRC_RANGE: srcRangeD = strbMerge(srcRangeQ, wrData, wrStrb);
        afm_pkg::OFF_DST_MODE:  dstModeD  = strbMerge(dstModeQ, wrData, wrStrb);
        afm_pkg::OFF_DST_RANGE: dstRangeD = strbMerge(dstRangeQ, wrData, wrStrb);
        afm_pkg::OFF_TCP_FLAGS: flagCfgD  = strbMerge(flagCfgQ, wrData, wrStrb);
        afm_pkg::OFF_CTRL:      ctrlD     = strbMerge(ctrlQ, wrData, wrStrb);
        afm_pkg::OFF_STATUS:    brespD    = afm_pkg::RESP_OKAY;
        default:                brespD    = afm_pkg::RESP_DECERR;
      endcase
    end
  end

  always_comb begin
    rvalidD = rvalidQ && !rready;
    rdataD  = rdataQ;
    rrespD  = rrespQ;
    if (arvalid && arready) begin
      rvalidD = 1'b1;
      rrespD  = afm_pkg::RESP_OKAY;
      case ({araddr[afm_pkg::ADDR_W-1:2], 2'b00})
        afm_pkg::OFF_ARP_CFG:   rdataD = arpCfgQ;
        afm_pkg::OFF_ICMP_CFG:  rdataD = icmpCfgQ;
        afm_pkg::OFF_SRC_MODE:  rdataD = srcModeQ;
        afm_pkg::OFF_SRC_RANGE: rdataD = srcRangeQ;
        afm_pkg::OFF_DST_MODE:  rdataD = dstModeQ;
        afm_pkg::OFF_DST_RANGE: rdataD = dstRangeQ;
        afm_pkg::OFF_TCP_FLAGS: rdataD = flagCfgQ;
        afm_pkg::OFF_CTRL:      rdataD = ctrlQ;
        afm_pkg::OFF_STATUS:    rdataD = statusWord;
        default: begin
          rdataD = '0;
          rrespD = afm_pkg::RESP_DECERR;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      arpCfgQ   <= afm_pkg::RST_ARP_CFG;
      icmpCfgQ  <= afm_pkg::RST_ICMP_CFG;
      srcModeQ  <= afm_pkg::RST_MODE;
      srcRangeQ <= afm_pkg::RST_RANGE;
      dstModeQ  <= afm_pkg::RST_MODE;
      dstRangeQ <= afm_pkg::RST_RANGE;
      flagCfgQ  <= afm_pkg::RST_TCP_FLAGS;
      ctrlQ     <= afm_pkg::RST_CTRL;
      awHeldQ   <= 1'b0;
      awAddrQ   <= '0;
      wHeldQ    <= 1'b0;
      wDataQ    <= '0;
      wStrbQ    <= '0;
      bvalidQ   <= 1'b0;
      brespQ    <= afm_pkg::RESP_OKAY;
      rvalidQ   <= 1'b0;
      rdataQ    <= '0;
      rrespQ    <= afm_pkg::RESP_OKAY;
    end else begin
      arpCfgQ   <= arpCfgD;
      icmpCfgQ  <= icmpCfgD;
      srcModeQ  <= srcModeD;
      srcRangeQ <= srcRangeD;
      dstModeQ  <= dstModeD;
      dstRangeQ <= dstRangeD;
      flagCfgQ  <= flagCfgD;
      ctrlQ     <= ctrlD;
      awHeldQ   <= awHeldD;
      awAddrQ   <= awAddrD;
      wHeldQ    <= wHeldD;
      wDataQ    <= wDataD;
      wStrbQ    <= wStrbD;
      bvalidQ   <= bvalidD;
      brespQ    <= brespD;
      rvalidQ   <= rvalidD;
      rdataQ    <= rdataD;
      rrespQ    <= rrespD;
    end
  end

  assign bvalid = bvalidQ;
  assign bresp  = brespQ;
  assign rvalid = rvalidQ;
  assign rdata  = rdataQ;
  assign rresp  = rrespQ;

  // ********************************************************
  // field matching
  // ********************************************************
  logic [1:0]        proSel, hrdSel;
  logic              typeEn, codeEn, srcCare, srcOk, dstCare, dstOk;
  logic              arpOk, icmpOk, portOk, flagOk, flagCare;
  afm_pkg::afm_range_s srcRange, dstRange;

  assign proSel   = arpCfgQ[afm_pkg::ARP_PRO_LSB +: 2];
  assign hrdSel   = arpCfgQ[afm_pkg::ARP_HRD_LSB +: 2];
  assign typeEn   = icmpCfgQ[afm_pkg::ICMP_TYPE_EN];
  assign codeEn   = icmpCfgQ[afm_pkg::ICMP_CODE_EN];
  assign srcRange = srcRangeQ;
  assign dstRange = dstRangeQ;

  afm_port_cond #(.PORT_W(16)) srcCond (
    .mode (srcModeQ[afm_pkg::MODE_LSB +: 2]),
    .lo   (srcRange.lo),
    .hi   (srcRange.hi),
    .port (hdr.srcPort),
    .care (srcCare),
    .ok   (srcOk)
  );  // [RULE4] [RULE5]

  afm_port_cond #(.PORT_W(16)) dstCond (
    .mode (dstModeQ[afm_pkg::MODE_LSB +: 2]),
    .lo   (dstRange.lo),
    .hi   (dstRange.hi),
    .port (hdr.dstPort),
    .care (dstCare),
    .ok   (dstOk)
  );  // [RULE6] [RULE7]

  always_comb begin
    // an active condition on a protocol the frame lacks fails the entry
    arpOk = !(triCare(proSel) || triCare(hrdSel)) ||
            (hdr.isArp && triOk(proSel, hdr.proType == afm_pkg::PRO_IP) &&
             triOk(hrdSel, hdr.hrdType == afm_pkg::HRD_ETHERNET));  // [RULE1] [RULE13] [RULE14]
    icmpOk = !(typeEn || codeEn) ||
             (hdr.isIcmp && (!typeEn || hdr.icmpType == icmpCfgQ[afm_pkg::ICMP_TYPE_LSB +: 8]) &&
              (!codeEn || hdr.icmpCode == icmpCfgQ[afm_pkg::ICMP_CODE_LSB +: 8]));  // [RULE2] [RULE3]
    portOk = !(srcCare || dstCare) || ((hdr.isTcp || hdr.isUdp) && srcOk && dstOk);  // [RULE14]
    flagCare = 1'b0;
    flagOk   = 1'b1;
    for (int i = 0; i < afm_pkg::NUM_FLAGS; i++) begin
      flagCare = flagCare || triCare(flagCfgQ[afm_pkg::FLAG_W*i +: 2]);
      flagOk   = flagOk && triOk(flagCfgQ[afm_pkg::FLAG_W*i +: 2], hdr.tcpFlags[i]);  // [RULE8] [RULE9] [RULE10] [RULE11] [RULE12]
    end
    flagOk = !flagCare || (hdr.isTcp && flagOk);
  end

  always_comb begin
    mValidD = hdrValid;  // [RULE15]
    hitD    = hitQ;
    seenD   = seenQ || hdrValid;
    cntD    = cntQ;
    if (hdrValid) begin
      hitD = ctrlQ[afm_pkg::CTRL_EN_BIT] && arpOk && icmpOk && portOk && flagOk;  // [RULE14]
      if (hitD && cntQ != {CNT_W{1'b1}}) begin
        cntD = cntQ + 1'b1;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      hitQ    <= 1'b0;
      seenQ   <= 1'b0;
      mValidQ <= 1'b0;
      cntQ    <= '0;
    end else begin
      hitQ    <= hitD;
      seenQ   <= seenD;
      mValidQ <= mValidD;
      cntQ    <= cntD;
    end
  end

  // hit stays at the last verdict; only matchValid marks a fresh one
  assign matchValid = mValidQ;
  assign matchHit   = hitQ;

  // ********************************************************
  // assertions
  // ********************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  valid_follows_a: assert property (hdrValid |=> matchValid) // [RULE15]
    else $error("match verdict missing one cycle after header");
  pro_zero_rejects_a: assert property (hdrValid && hdr.isArp && proSel == afm_pkg::TRI_ZERO &&
      hdr.proType == afm_pkg::PRO_IP |=> !matchHit) // [RULE1]
    else $error("protocol space 0 matched an ip frame");
  pro_one_requires_a: assert property (hdrValid && proSel == afm_pkg::TRI_ONE &&
      (!hdr.isArp || hdr.proType != afm_pkg::PRO_IP) |=> !matchHit) // [RULE1]
    else $error("protocol space 1 matched a non ip frame");
  hrd_zero_rejects_a: assert property (hdrValid && hdr.isArp && hrdSel == afm_pkg::TRI_ZERO &&
      hdr.hrdType == afm_pkg::HRD_ETHERNET |=> !matchHit) // [RULE13]
    else $error("hardware space 0 matched ethernet");
  icmp_type_exact_a: assert property (hdrValid && typeEn &&
      hdr.icmpType != icmpCfgQ[afm_pkg::ICMP_TYPE_LSB +: 8] |=> !matchHit) // [RULE2]
    else $error("icmp type mismatch matched");
  icmp_code_exact_a: assert property (hdrValid && codeEn &&
      hdr.icmpCode != icmpCfgQ[afm_pkg::ICMP_CODE_LSB +: 8] |=> !matchHit) // [RULE3]
    else $error("icmp code mismatch matched");
  src_port_exact_a: assert property (hdrValid && srcModeQ[1:0] == afm_pkg::PM_EXACT &&
      hdr.srcPort != srcRange.lo |=> !matchHit) // [RULE4]
    else $error("source port exact mismatch matched");
  src_range_bounds_a: assert property (hdrValid && srcModeQ[1:0] == afm_pkg::PM_RANGE &&
      (hdr.srcPort < srcRange.lo || hdr.srcPort > srcRange.hi) |=> !matchHit) // [RULE5]
    else $error("source port outside range matched");
  dst_port_exact_a: assert property (hdrValid && dstModeQ[1:0] == afm_pkg::PM_EXACT &&
      hdr.dstPort != dstRange.lo |=> !matchHit) // [RULE6]
    else $error("destination port exact mismatch matched");
  dst_range_bounds_a: assert property (hdrValid && dstModeQ[1:0] == afm_pkg::PM_RANGE &&
      (hdr.dstPort < dstRange.lo || hdr.dstPort > dstRange.hi) |=> !matchHit) // [RULE7]
    else $error("destination port outside range matched");
  fin_flag_a: assert property (hdrValid && hdr.isTcp && flagCfgQ[1:0] == afm_pkg::TRI_ZERO &&
      hdr.tcpFlags[afm_pkg::FLAG_FIN] |=> !matchHit) // [RULE8]
    else $error("fin setting 0 matched fin frame");
  syn_flag_a: assert property (hdrValid && flagCfgQ[3:2] == afm_pkg::TRI_ONE &&
      !(hdr.isTcp && hdr.tcpFlags[afm_pkg::FLAG_SYN]) |=> !matchHit) // [RULE9]
    else $error("syn setting 1 matched without syn");
  psh_ack_urg_a: assert property (hdrValid && hdr.isTcp && ((flagCfgQ[5:4] == afm_pkg::TRI_ZERO &&
      hdr.tcpFlags[afm_pkg::FLAG_PSH]) || (flagCfgQ[7:6] == afm_pkg::TRI_ZERO && hdr.tcpFlags[afm_pkg::FLAG_ACK]) ||
      (flagCfgQ[9:8] == afm_pkg::TRI_ZERO && hdr.tcpFlags[afm_pkg::FLAG_URG])) |=> !matchHit) // [RULE10] [RULE11] [RULE12]
    else $error("excluded tcp flag matched");
  all_any_hits_a: assert property (hdrValid && ctrlQ[0] && arpOk && icmpOk && portOk && flagOk
      |=> matchHit && ($past(cntQ) == {CNT_W{1'b1}} || cntQ == $past(cntQ) + 1'b1)) // [RULE14]
    else $error("all conditions held but no hit");
  bresp_holds_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped before ready");

  arp_hit_c: cover property (hdrValid && hdr.isArp && triCare(proSel) ##1 matchHit);
  range_hit_c: cover property (hdrValid && srcModeQ[1:0] == afm_pkg::PM_RANGE ##1 matchHit);
  flag_miss_c: cover property (hdrValid && hdr.isTcp && flagCare ##1 !matchHit);
  write_then_read_c: cover property (bvalid && bready ##[1:20] rvalid && rready);

endmodule

`default_nettype wire

// ==== testbench/afm_parser_model.sv ====
`timescale 1ns/1ps
`default_nettype none

// ********************************************************
// frame parser stand-in: one decoded header per call
// ********************************************************
module afm_parser_model (
  input  wire logic            clock,
  output var  logic            hdrValid,
  output var  afm_pkg::afm_hdr_s hdr
);
  initial begin
    hdrValid = 1'b0;
    hdr      = '0;
  end

  // fields are scrambled once the strobe drops so a stale header cannot match by luck
  task automatic send(input afm_pkg::afm_hdr_s x);
    hdrValid <= 1'b1;
    hdr      <= x;
    @(posedge clock);
    hdrValid <= 1'b0;
    hdr      <= ~x;
  endtask
endmodule

`default_nettype wire

// ==== testbench/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none

// ********************************************************
// bench for one filter list entry
// ********************************************************
module testbench;
  logic              clock, rst_n, awvalid, wvalid, bready, arvalid, rready;
  logic              awready, wready, bvalid, arready, rvalid;
  logic              hdrValid, matchValid, matchHit;
  logic [5:0]        awaddr, araddr, off;
  logic [31:0]       wdata, rdata;
  logic [3:0]        wstrb;
  logic [1:0]        bresp, rresp;
  afm_pkg::afm_hdr_s hdr, h;
  int                n_fail, checks_done, hits;

  afm_field_matcher i_afm_field_matcher (.clock(clock), .rst_n(rst_n), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
    .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid),
    .rready(rready), .rdata(rdata), .rresp(rresp), .hdrValid(hdrValid), .hdr(hdr),
    .matchValid(matchValid), .matchHit(matchHit));
  afm_parser_model i_afm_parser_model (.clock(clock), .hdrValid(hdrValid), .hdr(hdr));

  always #2.5 clock = ~clock;

  task automatic cmp(input string what, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask

  // handshakes are judged at the falling edge, where inputs and outputs are settled
  // ready comes one cycle after the answer so a held answer is exercised
  task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [1:0] er);
    logic       ta, tw, tb, tv;
    logic [1:0] r;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= 4'hF;
    tb = 1'b0;
    while (!tb) begin
      @(negedge clock);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid && bready;
      tv = bvalid;
      r  = bresp;
      @(posedge clock);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      bready <= tv && !tb;
    end
    cmp("bresp", {30'h0, er}, {30'h0, r});
  endtask

  task automatic rd(input logic [5:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic        ta, tr, tv;
    logic [31:0] d;
    logic [1:0]  r;
    arvalid <= 1'b1;
    araddr  <= a;
    tr = 1'b0;
    while (!tr) begin
      @(negedge clock);
      ta = arvalid && arready;
      tr = rvalid && rready;
      tv = rvalid;
      d  = rdata;
      r  = rresp;
      @(posedge clock);
      if (ta) arvalid <= 1'b0;
      rready <= tv && !tr;
    end
    cmp("rdata", ed, d);
    cmp("rresp", {30'h0, er}, {30'h0, r});
  endtask

  task automatic fr(input logic e);
    i_afm_parser_model.send(h);
    @(negedge clock);
    cmp("matchValid", 32'h1, {31'h0, matchValid});
    cmp("matchHit", {31'h0, e}, {31'h0, matchHit});
    if (e) hits++;
    @(posedge clock);
  endtask

  function automatic afm_pkg::afm_hdr_s mk(input int k);
    afm_pkg::afm_hdr_s x;
    x = '0;
    x.isArp = (k == 0);
    x.isIcmp = (k == 1);
    x.isTcp = (k == 2);
    x.isUdp = (k == 3);
    x.proType = afm_pkg::PRO_IP;
    x.hrdType = afm_pkg::HRD_ETHERNET;
    return x;
  endfunction

  task automatic pt(input int p, input logic [15:0] v, input logic e);
    h = mk(2);
    if (p == 1) h.dstPort = v;
    else h.srcPort = v;
    fr(e);
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // the whole sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clock);
    n_fail++;
    conclude;
  end

  initial begin
    {clock, rst_n, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, wstrb} = '0;
    h = '0;
    n_fail = 0;
    checks_done = 0;
    hits = 0;
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    rd(afm_pkg::OFF_ARP_CFG, 32'h0000_000A, afm_pkg::RESP_OKAY);
    rd(afm_pkg::OFF_TCP_FLAGS, 32'h0000_02AA, afm_pkg::RESP_OKAY);
    rd(afm_pkg::OFF_SRC_RANGE, 32'hFFFF_0000, afm_pkg::RESP_OKAY);
    rd(6'h24, 32'h0, afm_pkg::RESP_DECERR);
    wr(6'h28, 32'h1, afm_pkg::RESP_DECERR);
    h = mk(2);
    fr(1'b1);
    wr(afm_pkg::OFF_CTRL, 32'h0, afm_pkg::RESP_OKAY);
    fr(1'b0);
    wr(afm_pkg::OFF_CTRL, 32'h1, afm_pkg::RESP_OKAY);
    $display("registers and defaults done");
    h = mk(0);
    wr(afm_pkg::OFF_ARP_CFG, 32'h0000_0008, afm_pkg::RESP_OKAY);
    fr(1'b0);
    h.proType = 16'h0806;
    fr(1'b1);
    wr(afm_pkg::OFF_ARP_CFG, 32'h0000_0009, afm_pkg::RESP_OKAY);
    fr(1'b0);
    h = mk(0);
    fr(1'b1);
    h = mk(2);
    fr(1'b0);
    h = mk(0);
    wr(afm_pkg::OFF_ARP_CFG, 32'h0000_0002, afm_pkg::RESP_OKAY);
    fr(1'b0);
    wr(afm_pkg::OFF_ARP_CFG, 32'h0000_0006, afm_pkg::RESP_OKAY);
    fr(1'b1);
    h.hrdType = 16'h0006;
    fr(1'b0);
    wr(afm_pkg::OFF_ARP_CFG, 32'h0000_000A, afm_pkg::RESP_OKAY);
    $display("arp done");
    h = mk(1);
    h.icmpType = 8'h08;
    h.icmpCode = 8'hFF;
    wr(afm_pkg::OFF_ICMP_CFG, 32'h0000_0801, afm_pkg::RESP_OKAY);
    fr(1'b1);
    h.icmpType = 8'h09;
    fr(1'b0);
    wr(afm_pkg::OFF_ICMP_CFG, 32'h00FF_0002, afm_pkg::RESP_OKAY);
    fr(1'b1);
    h.icmpCode = 8'hFE;
    fr(1'b0);
    h = mk(2);
    fr(1'b0);
    wr(afm_pkg::OFF_ICMP_CFG, 32'h0, afm_pkg::RESP_OKAY);
    $display("icmp done");
    for (int p = 0; p < 2; p++) begin
      off = (p == 1) ? afm_pkg::OFF_DST_MODE : afm_pkg::OFF_SRC_MODE;
      wr(off, 32'h1, afm_pkg::RESP_OKAY);
      wr(off + 6'h04, 32'h0000_0050, afm_pkg::RESP_OKAY);
      pt(p, 16'h0050, 1'b1);
      pt(p, 16'h0051, 1'b0);
      wr(off, 32'h2, afm_pkg::RESP_OKAY);
      wr(off + 6'h04, 32'h07D0_03E8, afm_pkg::RESP_OKAY);
      pt(p, 16'h03E7, 1'b0);
      pt(p, 16'h03E8, 1'b1);
      pt(p, 16'h07D0, 1'b1);
      pt(p, 16'h07D1, 1'b0);
      h = mk(3);
      h.srcPort = 16'h0400;
      h.dstPort = 16'h0400;
      fr(1'b1);
      h = mk(1);
      fr(1'b0);
      wr(off, 32'h0, afm_pkg::RESP_OKAY);
    end
    $display("ports done");
    for (int f = 0; f < 5; f++) begin
      for (int s = 0; s < 2; s++) begin
        wr(afm_pkg::OFF_TCP_FLAGS, (32'h2AA & ~(32'h3 << (2 * f))) | (32'(s) << (2 * f)), afm_pkg::RESP_OKAY);
        h = mk(2);
        h.tcpFlags = 5'h1F;
        fr(s == 1);
        h.tcpFlags = ~(5'h01 << f);
        fr(s == 0);
      end
    end
    $display("tcp flags done");
    wr(afm_pkg::OFF_STATUS, 32'hFFFF_FFFF, afm_pkg::RESP_OKAY);
    rd(afm_pkg::OFF_STATUS, {16'(hits), 16'h0002}, afm_pkg::RESP_OKAY);
    $display("status done");
    conclude;
  end
endmodule

`default_nettype wire
